// >>> pkg/hbp_pkg.sv
// Purpose: Shared constants and types for the host bus port block
// Assumes: 125 MHz core clock, 16-bit register words
// Notes:   Offsets are byte addresses; 16-bit mode decodes word addresses
package hbp_pkg;
	// Clock and access timing
	localparam int          HBP_CLK_PERIOD_NS   = 8;
	localparam int          HBP_PORT_ACCESS_NS  = 40;
	localparam int          HBP_PORT_WAIT_INT   = (HBP_PORT_ACCESS_NS + HBP_CLK_PERIOD_NS - 1) / HBP_CLK_PERIOD_NS;
	localparam logic [3:0]  HBP_PORT_WAIT_CYC   = 4'(HBP_PORT_WAIT_INT);
	// Register byte offsets
	localparam logic [9:0]  HBP_OFS_GCR1        = 10'h000;
	localparam logic [9:0]  HBP_OFS_GCR2        = 10'h002;
	localparam logic [9:0]  HBP_OFS_ID          = 10'h004;
	localparam logic [9:0]  HBP_OFS_PCR1        = 10'h040;
	localparam logic [9:0]  HBP_OFS_PCR2        = 10'h042;
	localparam logic [9:0]  HBP_OFS_PCR3        = 10'h044;
	localparam logic [9:0]  HBP_OFS_PCR4        = 10'h046;
	localparam logic [9:0]  HBP_OFS_PLSR        = 10'h048;
	localparam logic [9:0]  HBP_OFS_TUNE_A      = 10'h20b;
	localparam logic [9:0]  HBP_OFS_TUNE_B      = 10'h20f;
	// Global control one fields
	localparam int          HBP_G1_RST          = 0;
	localparam int          HBP_G1_DP_RST       = 1;
	localparam int          HBP_G1_CLR_MODE     = 2;
	localparam logic [15:0] HBP_G1_MASK         = 16'h0007;
	localparam logic [15:0] HBP_G1_RESET        = 16'h0002;
	localparam logic [15:0] HBP_G2_MASK         = 16'h000f;
	localparam logic [15:0] HBP_G2_RESET        = 16'h0000;
	// Port control one fields
	localparam int          HBP_P1_DP_RST       = 0;
	localparam int          HBP_P1_PWRDN        = 1;
	localparam int          HBP_P1_LNAIS_LSB    = 10;
	localparam int          HBP_P1_DSAIS_LSB    = 12;
	localparam logic [15:0] HBP_P1_MASK         = 16'h7c03;
	localparam logic [15:0] HBP_P1_RESET        = 16'h0003;
	// Port control two fields
	localparam int          HBP_P2_FRAME_LSB    = 2;
	localparam int          HBP_P2_LMODE_LSB    = 8;
	localparam int          HBP_P2_TXLINE_EN    = 11;
	localparam logic [15:0] HBP_P2_MASK         = 16'h0f1f;
	localparam logic [15:0] HBP_P2_RESET        = 16'h0004;
	// Port control three fields
	localparam int          HBP_P3_LOOP_TIME    = 0;
	localparam int          HBP_P3_CLK_SRC      = 1;
	localparam logic [15:0] HBP_P3_MASK         = 16'h0003;
	localparam logic [15:0] HBP_P3_RESET        = 16'h0000;
	localparam logic [15:0] HBP_P4_MASK         = 16'hffff;
	localparam logic [15:0] HBP_P4_RESET        = 16'h0000;
	localparam logic [7:0]  HBP_TUNE_RESET      = 8'h00;
	// Field encodings
	localparam logic [2:0]  HBP_LMODE_UNIT_RX   = 3'h3;
	localparam logic [2:0]  HBP_FRAME_CBIT      = 3'h1;
	localparam logic [2:0]  HBP_FRAME_M13       = 3'h3;
	localparam logic [2:0]  HBP_DSAIS_OFF       = 3'h7;
	localparam logic [1:0]  HBP_LNAIS_OFF       = 2'h3;
	localparam logic [1:0]  HBP_SERIAL_BITS     = 2'h3;

	typedef enum logic [1:0] {HBP_IDLE, HBP_WAIT, HBP_DONE} hbp_state_e;
	typedef enum logic [1:0] {HBP_TXC_ADAPTER, HBP_TXC_INPUT, HBP_TXC_RECOVERED} hbp_txclk_e;
endpackage

// >>> hdl/hbp_sync.sv
// Purpose: Two flop synchroniser for pin inputs
// Assumes: Inputs stable around the sampled strobe
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module hbp_sync
#(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
	input  wire logic             core_clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_r;

	// Two stage capture
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_r <= RST_VAL;
			dout   <= RST_VAL;
		end
		else
		begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule // hbp_sync
`default_nettype wire

// >>> hdl/hbp_latch_bits.sv
// Purpose: Latched status bits with set-over-clear
// Assumes: Events and clears on core_clk
// Notes:   An event in the clearing cycle stays latched
`timescale 1ns/1ps
`default_nettype none
module hbp_latch_bits
#(
	parameter int WIDTH = 8
)
(
	input  wire logic             core_clk,
	input  wire logic             resetn,
	input  wire logic             hold_clear,
	input  wire logic [WIDTH-1:0] set_bits,
	input  wire logic [WIDTH-1:0] clr_bits,
	output logic      [WIDTH-1:0] latched
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			// Soft reset first, then set wins over clear
			always_ff @(posedge core_clk or negedge resetn)
			begin
				if (!resetn)
					latched[i] <= 1'b0;
				else if (hold_clear)
					latched[i] <= 1'b0;
				else if (set_bits[i])
					latched[i] <= 1'b1;
				else if (clr_bits[i])
					latched[i] <= 1'b0;
			end
		end
	endgenerate
endmodule // hbp_latch_bits
`default_nettype wire

// >>> hdl/hbp_host_port.sv
// Purpose: Parallel host port with global and port configuration
// Assumes: Read-write strobe bus, pins asynchronous to core_clk
// Notes:
// Notes on behaviour
// RQ1 - 8-bit: swap pin is address LSB, low byte
// RQ2 - 16-bit: swap pin exchanges data bytes
// RQ3 - Host keeps swap pin static
// RQ4 - 16-bit mode ignores address bit zero
// RQ5 - One global bit picks latched clear style
// RQ6 - Mode 1 clears on read, 0 on write
// RQ7 - Read returns contents, then clears them
// RQ8 - Write clears only bits written one
// RQ9 - Latency varies per location, ready marks done
// RQ10 - Ready low lets host end strobe
// RQ11 - Read-only identification register
// RQ12 - Global reset restores all registers
// RQ13 - Reset bit holds reset; default framer, unit off
// RQ14 - Datapath resets and powerdown default to one
// RQ15 - Transmit clock source from loop and source bits
// RQ16 - Line mode 011: line unit on, attenuator receive
// RQ17 - Alarm fields all ones disable insertion
// RQ18 - Line enable bit enables transmit line pins
// RQ19 - Example words select C-bit or M13 serial
// RQ20 - Software writes adapter tuning locations
// RQ21 - Unused control bits read zero
`timescale 1ns/1ps
`default_nettype none
module hbp_host_port
import hbp_pkg::*;
#(
	parameter logic [15:0] DEVICE_ID_CODE = 16'h5a3c // Arbitrary value
)
(
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic       cs_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic       bus_width_16,
	input  wire logic       addr_lsb_swap_select,
	input  wire logic [9:1] addr_hi,
	input  wire logic [15:0] data_in,
	output logic      [15:0] data_out,
	output logic            data_oe_lo,
	output logic            data_oe_hi,
	output logic            rdy_n,
	input  wire logic [7:0] port_events,
	output logic            global_reset_active,
	output logic            port_logic_reset,
	output logic      [3:0] adapter_config,
	output logic      [1:0] tx_clock_source,
	output logic            line_interface_enable,
	output logic            jitter_attenuator_rx,
	output logic      [2:0] framing_mode_field,
	output logic            ds3_cbit_serial,
	output logic            ds3_m13_serial,
	output logic            downstream_ais_enable,
	output logic            line_ais_enable,
	output logic            tx_line_enable,
	output logic      [7:0] tuning_a,
	output logic      [7:0] tuning_b
);
	localparam int         SYNC_W   = 30;
	localparam logic [29:0] SYNC_RST = 30'h3800_0000;

	logic [SYNC_W-1:0] sync_q;
	logic              s_cs_n, s_rd_n, s_wr_n, s_w16, s_swap;
	logic [9:1]        s_addr;
	logic [15:0]       s_data;
	hbp_state_e        st_r;
	logic [3:0]        cnt_r;
	logic              rd_r, w16_r, swap_r, a0_r;
	logic [9:1]        wa_r;
	logic [15:0]       wd_r, be_r;
	logic [15:0]       rd_word_r, data_out_r;
	logic [15:0]       gcr1_r, gcr2_r, pcr1_r, pcr2_r, pcr3_r, pcr4_r;
	logic [15:0]       tune_a_r, tune_b_r;
	logic [7:0]        plsr_q, plsr_clr;
	logic              strobe, hit, slow, commit, soft_rst, clr_mode;
	logic              wr_commit;
	logic [15:0]       rv;

	// Pin synchronisation
	hbp_sync #(.WIDTH(SYNC_W), .RST_VAL(SYNC_RST)) u_sync
	(
		.core_clk (core_clk),
		.resetn   (resetn),
		.din      ({cs_n, rd_n, wr_n, bus_width_16, addr_lsb_swap_select, addr_hi, data_in}),
		.dout     (sync_q)
	);
	assign {s_cs_n, s_rd_n, s_wr_n, s_w16, s_swap, s_addr, s_data} = sync_q;

	assign strobe    = !s_cs_n && (!s_rd_n || !s_wr_n);
	assign commit    = (st_r == HBP_WAIT) && (cnt_r == 4'h0);
	assign wr_commit = commit && !rd_r;
	assign soft_rst  = gcr1_r[HBP_G1_RST];
	assign clr_mode  = gcr1_r[HBP_G1_CLR_MODE];

	// Address decode on word address
	always_comb
	begin
		hit  = 1'b1;
		slow = 1'b0;
		case (s_addr)
			HBP_OFS_GCR1[9:1], HBP_OFS_GCR2[9:1], HBP_OFS_ID[9:1]: slow = 1'b0;
			HBP_OFS_PCR1[9:1], HBP_OFS_PCR2[9:1], HBP_OFS_PCR3[9:1],
			HBP_OFS_PCR4[9:1], HBP_OFS_PLSR[9:1]: slow = 1'b1;
			HBP_OFS_TUNE_A[9:1], HBP_OFS_TUNE_B[9:1]: slow = 1'b0;
			default: hit = 1'b0;
		endcase
	end

	// Read word of the captured address
	always_comb
	begin
		case (wa_r)
			HBP_OFS_GCR1[9:1]: rv = gcr1_r;
			HBP_OFS_GCR2[9:1]: rv = gcr2_r;
			// RQ11 identification readback
			HBP_OFS_ID[9:1]: rv = DEVICE_ID_CODE;
			HBP_OFS_PCR1[9:1]: rv = pcr1_r;
			HBP_OFS_PCR2[9:1]: rv = pcr2_r;
			HBP_OFS_PCR3[9:1]: rv = pcr3_r;
			HBP_OFS_PCR4[9:1]: rv = pcr4_r;
			HBP_OFS_PLSR[9:1]: rv = {8'h00, plsr_q};
			HBP_OFS_TUNE_A[9:1]: rv = tune_a_r;
			HBP_OFS_TUNE_B[9:1]: rv = tune_b_r;
			default: rv = 16'h0000;
		endcase
	end

	// RQ9 access sequencer with ready
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_r  <= HBP_IDLE;
			cnt_r <= 4'h0;
		end
		else
		begin
			case (st_r)
				HBP_IDLE:
					// Unmapped access never gets ready
					if (strobe && hit)
					begin
						st_r  <= HBP_WAIT;
						cnt_r <= slow ? HBP_PORT_WAIT_CYC : 4'h0;
					end
				HBP_WAIT:
					if (cnt_r == 4'h0)
						st_r <= HBP_DONE;
					else
						cnt_r <= cnt_r - 4'h1;
				// RQ10 hold ready until strobe ends
				HBP_DONE:
					if (!strobe)
						st_r <= HBP_IDLE;
				default: st_r <= HBP_IDLE;
			endcase
		end
	end

	// Capture of request at cycle start
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rd_r   <= 1'b0;
			w16_r  <= 1'b0;
			swap_r <= 1'b0;
			a0_r   <= 1'b0;
			wa_r   <= '0;
			wd_r   <= 16'h0000;
			be_r   <= 16'h0000;
		end
		else if ((st_r == HBP_IDLE) && strobe && hit)
		begin
			rd_r   <= !s_rd_n;
			w16_r  <= s_w16;
			swap_r <= s_swap;
			a0_r   <= s_swap;
			wa_r   <= s_addr;
			if (s_w16)
			begin
				// RQ4 whole word, RQ2 lane swap
				be_r <= 16'hffff;
				wd_r <= s_swap ? {s_data[7:0], s_data[15:8]} : s_data;
			end
			else
			begin
				// RQ1 low byte, pin as address LSB
				be_r <= s_swap ? 16'hff00 : 16'h00ff;
				wd_r <= {s_data[7:0], s_data[7:0]};
			end
		end
	end

	// Read data capture and lane mapping
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rd_word_r  <= 16'h0000;
			data_out_r <= 16'h0000;
		end
		else if (commit && rd_r)
		begin
			rd_word_r <= rv;
			if (w16_r)
				// RQ2 byte swap on read
				data_out_r <= swap_r ? {rv[7:0], rv[15:8]} : rv;
			else
				// RQ1 single byte on low lane
				data_out_r <= {8'h00, (a0_r ? rv[15:8] : rv[7:0])};
		end
	end

	assign data_out   = data_out_r;
	assign data_oe_lo = (st_r == HBP_DONE) && rd_r;
	assign data_oe_hi = (st_r == HBP_DONE) && rd_r && w16_r;
	assign rdy_n      = !(st_r == HBP_DONE);

	// RQ12 RQ13 global registers and soft reset
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			gcr1_r   <= HBP_G1_RESET;
			gcr2_r   <= HBP_G2_RESET;
			tune_a_r <= {HBP_TUNE_RESET, 8'h00};
			tune_b_r <= {HBP_TUNE_RESET, 8'h00};
		end
		else if (soft_rst)
		begin
			// Only the reset bit itself stays writable
			gcr1_r <= HBP_G1_RESET;
			if (wr_commit && (wa_r == HBP_OFS_GCR1[9:1]))
				gcr1_r[HBP_G1_RST] <= (wd_r[HBP_G1_RST] & be_r[HBP_G1_RST]);
			else
				gcr1_r[HBP_G1_RST] <= 1'b1;
			gcr2_r   <= HBP_G2_RESET;
			tune_a_r <= {HBP_TUNE_RESET, 8'h00};
			tune_b_r <= {HBP_TUNE_RESET, 8'h00};
		end
		else if (wr_commit)
		begin
			case (wa_r)
				HBP_OFS_GCR1[9:1]: gcr1_r <= ((gcr1_r & ~be_r) | (wd_r & be_r)) & HBP_G1_MASK;
				HBP_OFS_GCR2[9:1]: gcr2_r <= ((gcr2_r & ~be_r) | (wd_r & be_r)) & HBP_G2_MASK;
				// RQ20 adapter tuning bytes, upper lane
				HBP_OFS_TUNE_A[9:1]: tune_a_r <= ((tune_a_r & ~be_r) | (wd_r & be_r)) & 16'hff00;
				HBP_OFS_TUNE_B[9:1]: tune_b_r <= ((tune_b_r & ~be_r) | (wd_r & be_r)) & 16'hff00;
				default: gcr1_r <= gcr1_r;
			endcase
		end
	end

	// RQ14 RQ21 port registers, masked, one defaults
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pcr1_r <= HBP_P1_RESET;
			pcr2_r <= HBP_P2_RESET;
			pcr3_r <= HBP_P3_RESET;
			pcr4_r <= HBP_P4_RESET;
		end
		else if (soft_rst)
		begin
			pcr1_r <= HBP_P1_RESET;
			pcr2_r <= HBP_P2_RESET;
			pcr3_r <= HBP_P3_RESET;
			pcr4_r <= HBP_P4_RESET;
		end
		else if (wr_commit)
		begin
			case (wa_r)
				HBP_OFS_PCR1[9:1]: pcr1_r <= ((pcr1_r & ~be_r) | (wd_r & be_r)) & HBP_P1_MASK;
				HBP_OFS_PCR2[9:1]: pcr2_r <= ((pcr2_r & ~be_r) | (wd_r & be_r)) & HBP_P2_MASK;
				HBP_OFS_PCR3[9:1]: pcr3_r <= ((pcr3_r & ~be_r) | (wd_r & be_r)) & HBP_P3_MASK;
				HBP_OFS_PCR4[9:1]: pcr4_r <= ((pcr4_r & ~be_r) | (wd_r & be_r)) & HBP_P4_MASK;
				default: pcr1_r <= pcr1_r;
			endcase
		end
	end

	// RQ5 RQ6 RQ7 RQ8 latched clear selection
	always_comb
	begin
		plsr_clr = 8'h00;
		if (commit && (wa_r == HBP_OFS_PLSR[9:1]))
		begin
			if (rd_r && clr_mode)
				plsr_clr = plsr_q;
			else if (!rd_r && !clr_mode)
				plsr_clr = wd_r[7:0] & be_r[7:0];
		end
	end

	hbp_latch_bits #(.WIDTH(8)) u_plsr
	(
		.core_clk   (core_clk),
		.resetn     (resetn),
		.hold_clear (soft_rst),
		.set_bits   (port_events),
		.clr_bits   (plsr_clr),
		.latched    (plsr_q)
	);

	// Configuration decode to the datapath
	assign global_reset_active = soft_rst;
	// RQ14 datapath held until bits cleared
	assign port_logic_reset = soft_rst || gcr1_r[HBP_G1_DP_RST] || pcr1_r[HBP_P1_DP_RST] || pcr1_r[HBP_P1_PWRDN];
	assign adapter_config   = gcr2_r[3:0];
	// RQ15 transmit clock selection
	assign tx_clock_source = pcr3_r[HBP_P3_LOOP_TIME] ? HBP_TXC_RECOVERED :
		(pcr3_r[HBP_P3_CLK_SRC] ? HBP_TXC_INPUT : HBP_TXC_ADAPTER);
	// RQ16 line mode with receive attenuator
	assign line_interface_enable = (pcr2_r[HBP_P2_LMODE_LSB+:3] != 3'h0);
	assign jitter_attenuator_rx  = (pcr2_r[HBP_P2_LMODE_LSB+:3] == HBP_LMODE_UNIT_RX);
	assign framing_mode_field    = pcr2_r[HBP_P2_FRAME_LSB+:3];
	// RQ19 serial framing decode
	assign ds3_cbit_serial = (framing_mode_field == HBP_FRAME_CBIT) && (pcr2_r[1:0] == HBP_SERIAL_BITS);
	assign ds3_m13_serial  = (framing_mode_field == HBP_FRAME_M13) && (pcr2_r[1:0] == HBP_SERIAL_BITS);
	// RQ17 alarm insertion disables
	assign downstream_ais_enable = (pcr1_r[HBP_P1_DSAIS_LSB+:3] != HBP_DSAIS_OFF);
	assign line_ais_enable       = (pcr1_r[HBP_P1_LNAIS_LSB+:2] != HBP_LNAIS_OFF);
	// RQ18 transmit line pins
	assign tx_line_enable = pcr2_r[HBP_P2_TXLINE_EN];
	assign tuning_a       = tune_a_r[15:8];
	assign tuning_b       = tune_b_r[15:8];

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence slow_start;
		(st_r == HBP_IDLE) && strobe && hit && slow;
	endsequence
	sequence slow_wait;
		(st_r == HBP_WAIT)[*6];
	endsequence

	AST_PORT_LATENCY: assert property (slow_start |=> slow_wait ##1 !rdy_n) // RQ9
		else $error("port access latency wrong");
	AST_RDY_HOLD: assert property (!rdy_n && strobe |=> !rdy_n) // RQ10
		else $error("ready dropped before strobe end");
	AST_NARROW_LANE: assert property (!w16_r && rd_r && !rdy_n |-> !data_oe_hi && data_out[15:8] == 8'h00) // RQ1
		else $error("upper lane used in 8-bit mode");
	AST_SWAP_READ: assert property (commit && rd_r && w16_r && swap_r |=> data_out == {rd_word_r[7:0], rd_word_r[15:8]}) // RQ2
		else $error("byte swap wrong");
	AST_WORD_WRITE: assert property (wr_commit && w16_r |-> be_r == 16'hffff) // RQ4
		else $error("16-bit write not whole word");
	AST_CLR_READ: assert property (commit && rd_r && clr_mode && wa_r == HBP_OFS_PLSR[9:1]
		|=> (plsr_q & ~$past(port_events)) == 8'h00) // RQ7
		else $error("clear on read left bits");
	AST_CLR_WRITE: assert property (wr_commit && !clr_mode && !soft_rst && wa_r == HBP_OFS_PLSR[9:1]
		|=> plsr_q == (($past(plsr_q) & ~($past(wd_r[7:0]) & $past(be_r[7:0]))) | $past(port_events))) // RQ8
		else $error("clear on write wrong");
	AST_SOFT_RESET: assert property (soft_rst |=> pcr1_r == HBP_P1_RESET && pcr2_r == HBP_P2_RESET) // RQ12
		else $error("soft reset did not restore port registers");
	AST_DP_HELD: assert property (pcr1_r[HBP_P1_PWRDN] |-> port_logic_reset) // RQ14
		else $error("powerdown not holding datapath");
	AST_LOOP_CLOCK: assert property (pcr3_r[HBP_P3_LOOP_TIME] |-> tx_clock_source == HBP_TXC_RECOVERED) // RQ15
		else $error("loop timing not selected");
	AST_LIU_JA: assert property (pcr2_r[10:8] == 3'h3 |-> line_interface_enable && jitter_attenuator_rx) // RQ16
		else $error("line mode 011 decode wrong");
	AST_AIS_OFF: assert property (pcr1_r[14:10] == 5'h1f |-> !downstream_ais_enable && !line_ais_enable) // RQ17
		else $error("alarm insertion not disabled");
endmodule // hbp_host_port
`default_nettype wire

// >>> tb/hbp_host_model.sv
// Purpose: Host processor model driving the read-write strobe bus
// Assumes: Ready sampled on rising core_clk edges, pins change 1 ns later
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module hbp_host_model
(
	input  wire logic        core_clk,
	input  wire logic        bus16,
	input  wire logic        swap_cfg,
	input  wire logic [15:0] data_out,
	input  wire logic        rdy_n,
	output logic             cs_n,
	output logic             rd_n,
	output logic             wr_n,
	output logic             addr_lsb_swap_select,
	output logic       [9:1] addr_hi,
	output logic      [15:0] data_in
);
	// Idle bus at time zero
	initial
	begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		addr_lsb_swap_select = 1'b0;
		addr_hi = 9'h000;
		data_in = 16'h0000;
	end

	// One bus cycle; lat counts edges until ready, ok is low on a hang
	task automatic access(input logic wr, input logic [9:0] addr, input logic [15:0] wdata,
		output logic [15:0] rdata, output int lat, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		@(posedge core_clk);
		#1;
		addr_hi = addr[9:1];
		addr_lsb_swap_select = bus16 ? swap_cfg : addr[0];
		data_in = wr ? wdata : ~data_in;
		cs_n = 1'b0;
		rd_n = wr;
		wr_n = !wr;
		while (!ok && n < 64)
		begin
			@(posedge core_clk);
			n++;
			ok = (rdy_n === 1'b0);
		end
		rdata = data_out;
		lat = n;
		#1;
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		data_in = ~data_in;
		n = 0;
		while (rdy_n !== 1'b1 && n < 16)
		begin
			@(posedge core_clk);
			n++;
		end
	endtask
endmodule // hbp_host_model
`default_nettype wire

// >>> tb/hbp_host_port_tb_top.sv
// Purpose: Self-checking bench for the host bus port
// Assumes: 125 MHz core_clk, host model makes every bus cycle
// Notes:   Width and swap pins change only while resetn is low
`timescale 1ns/1ps
`default_nettype none
module hbp_host_port_tb_top
import hbp_pkg::*;
;
	localparam logic [15:0] ID = 16'h1e2d; // Arbitrary value
	logic        core_clk, resetn, bus_width_16, swap_cfg, cs_n, rd_n, wr_n;
	logic        addr_lsb_swap_select, data_oe_lo, data_oe_hi, rdy_n;
	logic        global_reset_active, port_logic_reset, line_interface_enable, jitter_attenuator_rx;
	logic        ds3_cbit_serial, ds3_m13_serial, downstream_ais_enable, line_ais_enable, tx_line_enable;
	logic  [9:1] addr_hi;
	logic [15:0] data_in, data_out;
	logic  [7:0] port_events, tuning_a, tuning_b;
	logic  [3:0] adapter_config;
	logic  [1:0] tx_clock_source;
	logic  [2:0] framing_mode_field;
	int          err_count, comparisons, cycles;
	logic [15:0] rv;
	int          lg, lp;
	logic        ok;
	localparam logic [9:0]  OFS[6] = '{HBP_OFS_GCR1, HBP_OFS_GCR2, HBP_OFS_ID, HBP_OFS_PCR1, HBP_OFS_PCR2,
		HBP_OFS_PCR3};
	localparam logic [15:0] DFL[6] = '{16'h0002, 16'h0000, ID, 16'h0003, 16'h0004, 16'h0000};
	localparam logic [1:0]  TXC[4] = '{2'h0, 2'h2, 2'h1, 2'h2};

	// Clock and timeout
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_count++;
			conclude();
		end
	end

	// Read lanes driven at the ready edge
	always @(posedge core_clk)
		if (!rdy_n && !rd_n)
			check("read enables", {14'h0000, data_oe_hi, data_oe_lo}, {14'h0000, bus_width_16, 1'b1});

	hbp_host_model host (.core_clk(core_clk), .bus16(bus_width_16), .swap_cfg(swap_cfg), .data_out(data_out),
		.rdy_n(rdy_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr_lsb_swap_select(addr_lsb_swap_select),
		.addr_hi(addr_hi), .data_in(data_in));

	hbp_host_port #(.DEVICE_ID_CODE(ID)) dut (.core_clk(core_clk), .resetn(resetn), .cs_n(cs_n), .rd_n(rd_n),
		.wr_n(wr_n), .bus_width_16(bus_width_16), .addr_lsb_swap_select(addr_lsb_swap_select),
		.addr_hi(addr_hi), .data_in(data_in), .data_out(data_out), .data_oe_lo(data_oe_lo),
		.data_oe_hi(data_oe_hi), .rdy_n(rdy_n), .port_events(port_events),
		.global_reset_active(global_reset_active), .port_logic_reset(port_logic_reset),
		.adapter_config(adapter_config), .tx_clock_source(tx_clock_source),
		.line_interface_enable(line_interface_enable), .jitter_attenuator_rx(jitter_attenuator_rx),
		.framing_mode_field(framing_mode_field), .ds3_cbit_serial(ds3_cbit_serial),
		.ds3_m13_serial(ds3_m13_serial), .downstream_ais_enable(downstream_ais_enable),
		.line_ais_enable(line_ais_enable), .tx_line_enable(tx_line_enable), .tuning_a(tuning_a),
		.tuning_b(tuning_b));

	// Verdict and end of run
	task automatic conclude();
		if (err_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Compare and count
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Register write and read
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		logic [15:0] r;
		int          l;
		logic        k;
		host.access(1'b1, a, d, r, l, k);
		check("write ready", {15'h0000, k}, 16'h0001);
	endtask
	task automatic rd(input logic [9:0] a, input logic [15:0] exp, input string name);
		logic [15:0] r;
		int          l;
		logic        k;
		host.access(1'b0, a, 16'h0000, r, l, k);
		check("read ready", {15'h0000, k}, 16'h0001);
		check(name, r, exp);
	endtask

	// Pin reset with chosen width and swap
	task automatic pin_reset(input logic b16, input logic sw);
		@(posedge core_clk);
		#1;
		resetn = 1'b0;
		bus_width_16 = b16;
		swap_cfg = sw;
		repeat (20) @(posedge core_clk);
		#1;
		resetn = 1'b1;
	endtask

	// One cycle event pulse
	task automatic pulse(input logic [7:0] v);
		@(posedge core_clk);
		#1;
		port_events = v;
		@(posedge core_clk);
		#1;
		port_events = 8'h00;
	endtask

	// Main sequence
	initial
	begin
		core_clk = 1'b0;
		resetn = 1'b0;
		bus_width_16 = 1'b1;
		swap_cfg = 1'b0;
		port_events = 8'h00;
		err_count = 0;
		comparisons = 0;
		cycles = 0;
		pin_reset(1'b1, 1'b0);
		foreach (OFS[i]) rd(OFS[i], DFL[i], "default");
		check("framing", {13'h0000, framing_mode_field}, 16'h0001);
		check("line unit", {15'h0000, line_interface_enable}, 16'h0000);
		check("port reset", {15'h0000, port_logic_reset}, 16'h0001);
		wr(HBP_OFS_ID, 16'hffff);
		rd(HBP_OFS_ID, ID, "id");
		wr(HBP_OFS_PCR1, 16'hffff);
		rd(HBP_OFS_PCR1, 16'h7c03, "pcr1 unused");
		wr(HBP_OFS_PCR2, 16'hffff);
		rd(HBP_OFS_PCR2, 16'h0f1f, "pcr2 unused");
		check("tx line", {15'h0000, tx_line_enable}, 16'h0001);
		wr(HBP_OFS_PCR1, 16'h7c00);
		wr(HBP_OFS_GCR1, 16'h0000);
		check("port reset off", {15'h0000, port_logic_reset}, 16'h0000);
		wr(HBP_OFS_PCR2, 16'h0307);
		check("cbit", {14'h0000, ds3_cbit_serial, ds3_m13_serial}, 16'h0002);
		check("unit atten", {14'h0000, line_interface_enable, jitter_attenuator_rx}, 16'h0003);
		check("ais", {14'h0000, downstream_ais_enable, line_ais_enable}, 16'h0000);
		wr(HBP_OFS_PCR2, 16'h030f);
		check("m13", {14'h0000, ds3_cbit_serial, ds3_m13_serial}, 16'h0001);
		wr(HBP_OFS_GCR2, 16'h00fa);
		check("adapter", {12'h000, adapter_config}, 16'h000a);
		for (int i = 0; i < 4; i++)
		begin
			wr(HBP_OFS_PCR3, 16'(i));
			check("tx clock", {14'h0000, tx_clock_source}, {14'h0000, TXC[i]});
		end
		host.access(1'b0, HBP_OFS_GCR2, 16'h0000, rv, lg, ok);
		host.access(1'b0, HBP_OFS_PCR4, 16'h0000, rv, lp, ok);
		check("latency gap", 16'(lp - lg), 16'h0005);
		host.access(1'b0, 10'h3f0, 16'h0000, rv, lg, ok);
		check("unmapped ready", {15'h0000, ok}, 16'h0000);
		pulse(8'ha5);
		rd(HBP_OFS_PLSR, 16'h00a5, "latched");
		rd(HBP_OFS_PLSR, 16'h00a5, "kept on read");
		wr(HBP_OFS_PLSR, 16'h0005);
		rd(HBP_OFS_PLSR, 16'h00a0, "write clear");
		wr(HBP_OFS_PLSR, 16'h00ff);
		wr(HBP_OFS_GCR1, 16'h0004);
		pulse(8'h3c);
		rd(HBP_OFS_PLSR, 16'h003c, "read value");
		rd(HBP_OFS_PLSR, 16'h0000, "read clear");
		wr(HBP_OFS_GCR1, 16'h0001);
		check("soft reset", {15'h0000, global_reset_active}, 16'h0001);
		rd(HBP_OFS_PCR2, 16'h0004, "held pcr2");
		check("adapter reset", {12'h000, adapter_config}, 16'h0000);
		wr(HBP_OFS_GCR1, 16'h0000);
		rd(HBP_OFS_PCR1, 16'h0003, "after soft");
		check("unit off", {15'h0000, line_interface_enable}, 16'h0000);
		pin_reset(1'b0, 1'b0);
		wr(HBP_OFS_TUNE_A, 16'h0011);
		wr(HBP_OFS_TUNE_B, 16'h0011);
		check("tuning", {tuning_a, tuning_b}, 16'h1111);
		rd(HBP_OFS_TUNE_A, 16'h0011, "byte read");
		wr(10'h041, 16'h007c);
		rd(10'h040, 16'h0003, "low lane");
		rd(10'h041, 16'h007c, "high lane");
		pin_reset(1'b1, 1'b1);
		wr(HBP_OFS_PCR1, 16'h037c);
		check("swap write", {15'h0000, line_ais_enable}, 16'h0000);
		rd(HBP_OFS_PCR1, 16'h037c, "swap read");
		conclude();
	end
endmodule // hbp_host_port_tb_top
`default_nettype wire
